// ---- src/hbfp_pkg.sv ----
`default_nettype none

package hbfp_pkg;

    // ------------------------------------------------------------------
    // Geometry and clock
    // ------------------------------------------------------------------
    localparam int NUM_BRIDGES  = 4;
    localparam int NUM_SWITCHES = 2 * NUM_BRIDGES;
    localparam int CLK_FREQ_MHZ = 40;
    localparam int SYNC_WIDTH   = 2 * NUM_SWITCHES + 5;

    // ------------------------------------------------------------------
    // Timing: figures in ns, cycle counts rounded up
    // ------------------------------------------------------------------
    localparam int OC_FILTER_NS     = 10000;
    localparam int OL_FILTER_NS     = 50000;
    localparam int DEAD_TIME_NS     = 1000;
    localparam int OC_FILTER_CYCLES =
        (OC_FILTER_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int OL_FILTER_CYCLES =
        (OL_FILTER_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int DEAD_TIME_CYCLES =
        (DEAD_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] GLOBAL_STATUS_RESET = 8'h00;
    localparam logic [7:0] SWITCH_FLAGS_RESET  = 8'h00;
    localparam logic [3:0] GATES_OFF           = 4'h0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_BRIDGES-1:0] low;
        logic [NUM_BRIDGES-1:0] high;
    } hbfp_switch_t;

    typedef struct packed {
        logic reserved_hi;
        logic load_fault_summary;
        logic supply_under_voltage_flag;
        logic supply_over_voltage_flag;
        logic power_up_seen_flag;
        logic thermal_shutdown_flag;
        logic thermal_warning_flag;
        logic reserved_lo;
    } hbfp_global_t;

    typedef struct packed {
        hbfp_switch_t overcurrent;
        hbfp_switch_t open_load;
        hbfp_global_t global_bits;
    } hbfp_clear_t;

endpackage : hbfp_pkg

`default_nettype wire

// ---- src/hbfp_filter.sv ----
`default_nettype none

module hbfp_filter #(
    parameter int CYCLES = 400,
    localparam int W     = $clog2(CYCLES + 1)
) (
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    input  wire logic flush_in,
    input  wire logic active_in,
    output logic      running_out,
    output logic      done_out
);

    logic [W-1:0] count_reg;

    // ------------------------------------------------------------------
    // Qualification counter, saturates once expired
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= '0;
        end else if (flush_in || !active_in) begin
            count_reg <= '0;
        end else if (count_reg < W'(CYCLES)) begin
            count_reg <= count_reg + W'(1);
        end
    end

    assign running_out = active_in && !flush_in
        && (count_reg < W'(CYCLES));
    assign done_out    = active_in && !flush_in
        && (count_reg == W'(CYCLES - 1));

endmodule : hbfp_filter

`default_nettype wire

// ---- src/hbfp_top.sv ----
`default_nettype none

// Functional notes
// - Overcurrent held through filter time latches switch off and sets its flag.
// - Current clamp stays active while filter runs; no early turn-off.
// - Any latched overcurrent flag sets the global load fault bit.
// - Switch stays off while its overcurrent flag is set; enables untouched.
// - High and low side never on together; dead time between them.
// - Thermal warning sets a latched flag; outputs stay enabled.
// - Thermal shutdown latches all outputs off and sets its flag.
// - Outputs stay off until thermal shutdown flag cleared; enables kept.
// - Supply undervoltage turns outputs off, latches flag, auto recovers.
// - Supply overvoltage turns outputs off, latches flag, auto recovers.
// - Logic supply reset initializes logic and turns all stages off.
// - After reset the power-up flag reads zero while enabled.
// - Undercurrent on an enabled switch past filter latches open-load flag.
// - Any latched open-load flag sets the global load fault bit.
// - Global fault is OR of global bits, power-up inverted, open load masked.
// - Load fault bit is OR of all overcurrent and open-load flags.
// - Flags clear only on access with operation bit one or on enable low.
// - Enable low turns all outputs off and resets all flags.
module hbfp_top #(
    parameter int OC_CYCLES   = hbfp_pkg::OC_FILTER_CYCLES,
    parameter int OL_CYCLES   = hbfp_pkg::OL_FILTER_CYCLES,
    parameter int DEAD_CYCLES = hbfp_pkg::DEAD_TIME_CYCLES
) (
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   enable_in,
    input  wire hbfp_pkg::hbfp_switch_t bridge_activation_control_in,
    input  wire hbfp_pkg::hbfp_switch_t overcurrent_raw_in,
    input  wire hbfp_pkg::hbfp_switch_t undercurrent_raw_in,
    input  wire logic                   thermal_warning_raw_in,
    input  wire logic                   thermal_shutdown_raw_in,
    input  wire logic                   supply_under_voltage_raw_in,
    input  wire logic                   supply_over_voltage_raw_in,
    input  wire logic                   open_load_mask_in,
    input  wire logic                   clear_strobe_in,
    input  wire logic                   access_operation_bit_in,
    input  wire hbfp_pkg::hbfp_clear_t  clear_select_in,
    output hbfp_pkg::hbfp_switch_t      gate_drive_out,
    output hbfp_pkg::hbfp_switch_t      current_limit_out,
    output hbfp_pkg::hbfp_switch_t      overcurrent_status_out,
    output hbfp_pkg::hbfp_switch_t      open_load_status_out,
    output hbfp_pkg::hbfp_global_t      global_status_one_out,
    output logic                        global_fault_indicator_out
);

    localparam int NB = hbfp_pkg::NUM_BRIDGES;
    localparam int NS = hbfp_pkg::NUM_SWITCHES;
    localparam int DW = $clog2(DEAD_CYCLES + 1);

    // ------------------------------------------------------------------
    // Input synchronizers
    // ------------------------------------------------------------------
    logic [hbfp_pkg::SYNC_WIDTH-1:0] sync1_reg;
    logic [hbfp_pkg::SYNC_WIDTH-1:0] sync2_reg;
    logic [NS-1:0]                   oc_s;
    logic [NS-1:0]                   uc_s;
    logic                            warn_s;
    logic                            shut_s;
    logic                            uv_s;
    logic                            ov_s;
    logic                            enable_s;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {enable_in, supply_over_voltage_raw_in,
                          supply_under_voltage_raw_in,
                          thermal_shutdown_raw_in, thermal_warning_raw_in,
                          undercurrent_raw_in, overcurrent_raw_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign {enable_s, ov_s, uv_s, shut_s, warn_s, uc_s, oc_s} = sync2_reg;

    // ------------------------------------------------------------------
    // Per-switch filters
    // ------------------------------------------------------------------
    logic [NS-1:0] gate_reg;
    logic [NS-1:0] oc_flag_reg;
    logic [NS-1:0] ol_flag_reg;
    logic [NS-1:0] oc_run;
    logic [NS-1:0] oc_done;
    logic [NS-1:0] ol_done;

    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_filter
            hbfp_filter #(
                .CYCLES (OC_CYCLES)
            ) u_oc_filter (
                .core_clk_in (core_clk_in),
                .rst_n_in    (rst_n_in),
                .flush_in    (!enable_s || oc_flag_reg[gi]),
                .active_in   (oc_s[gi]),
                .running_out (oc_run[gi]),
                .done_out    (oc_done[gi])
            );
            hbfp_filter #(
                .CYCLES (OL_CYCLES)
            ) u_ol_filter (
                .core_clk_in (core_clk_in),
                .rst_n_in    (rst_n_in),
                .flush_in    (!enable_s || ol_flag_reg[gi]),
                .active_in   (gate_reg[gi] && uc_s[gi]),
                .running_out (),
                .done_out    (ol_done[gi])
            );
        end
    endgenerate

    // Clamp current while the overcurrent filter runs
    assign current_limit_out = hbfp_pkg::hbfp_switch_t'(oc_run);

    // ------------------------------------------------------------------
    // Latched flags
    // ------------------------------------------------------------------
    function automatic logic [NS-1:0] hbfp_latch(
        input logic [NS-1:0] cur,
        input logic [NS-1:0] set,
        input logic [NS-1:0] clr
    );
        hbfp_latch = (cur & ~clr) | set;
    endfunction : hbfp_latch

    logic                  clr_ok;
    hbfp_pkg::hbfp_global_t status_reg;
    hbfp_pkg::hbfp_global_t sel_g;
    logic [NS-1:0]         oc_flag_next;
    logic [NS-1:0]         ol_flag_next;

    assign clr_ok = clear_strobe_in && access_operation_bit_in;
    assign sel_g  = clear_select_in.global_bits;
    assign oc_flag_next = hbfp_latch(oc_flag_reg, oc_done,
        clr_ok ? clear_select_in.overcurrent : '0);
    assign ol_flag_next = hbfp_latch(ol_flag_reg, ol_done,
        clr_ok ? clear_select_in.open_load : '0);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            oc_flag_reg <= hbfp_pkg::SWITCH_FLAGS_RESET;
            ol_flag_reg <= hbfp_pkg::SWITCH_FLAGS_RESET;
        end else if (!enable_s) begin
            oc_flag_reg <= hbfp_pkg::SWITCH_FLAGS_RESET;
            ol_flag_reg <= hbfp_pkg::SWITCH_FLAGS_RESET;
        end else begin
            oc_flag_reg <= oc_flag_next;
            ol_flag_reg <= ol_flag_next;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_reg <= hbfp_pkg::GLOBAL_STATUS_RESET;
        end else if (!enable_s) begin
            status_reg <= hbfp_pkg::GLOBAL_STATUS_RESET;
        end else begin
            status_reg.load_fault_summary <=
                |(oc_flag_next | ol_flag_next);
            status_reg.thermal_warning_flag <=
                (status_reg.thermal_warning_flag
                 && !(clr_ok && sel_g.thermal_warning_flag))
                || warn_s;
            status_reg.thermal_shutdown_flag <=
                (status_reg.thermal_shutdown_flag
                 && !(clr_ok && sel_g.thermal_shutdown_flag))
                || shut_s;
            status_reg.supply_under_voltage_flag <=
                (status_reg.supply_under_voltage_flag
                 && !(clr_ok && sel_g.supply_under_voltage_flag))
                || uv_s;
            status_reg.supply_over_voltage_flag <=
                (status_reg.supply_over_voltage_flag
                 && !(clr_ok && sel_g.supply_over_voltage_flag))
                || ov_s;
            status_reg.power_up_seen_flag <=
                status_reg.power_up_seen_flag
                || (clr_ok && sel_g.power_up_seen_flag);
        end
    end

    assign overcurrent_status_out = hbfp_pkg::hbfp_switch_t'(oc_flag_reg);
    assign open_load_status_out   = hbfp_pkg::hbfp_switch_t'(ol_flag_reg);
    assign global_status_one_out  = status_reg;
    assign global_fault_indicator_out =
        status_reg.supply_under_voltage_flag
        || status_reg.supply_over_voltage_flag
        || !status_reg.power_up_seen_flag
        || status_reg.thermal_shutdown_flag
        || status_reg.thermal_warning_flag
        || (|oc_flag_reg)
        || ((|ol_flag_reg) && !open_load_mask_in);

    // ------------------------------------------------------------------
    // Gate drive with dead time
    // ------------------------------------------------------------------
    logic [NS-1:0] request;
    logic          stage_ok;

    assign stage_ok = enable_s && !uv_s && !ov_s
        && !status_reg.thermal_shutdown_flag;
    assign request = bridge_activation_control_in & ~oc_flag_reg
        & {NS{stage_ok}};

    generate
        for (gi = 0; gi < NB; gi++) begin : g_bridge
            logic [DW-1:0] dead_reg;
            logic          hs_next;
            logic          ls_next;
            logic          hs_q;
            logic          ls_q;

            assign hs_q = gate_reg[gi];
            assign ls_q = gate_reg[gi + NB];
            assign hs_next = request[gi] && !request[gi + NB] && !ls_q
                && (dead_reg == '0);
            assign ls_next = request[gi + NB] && !request[gi] && !hs_q
                && (dead_reg == '0);

            always_ff @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    dead_reg     <= '0;
                    gate_reg[gi]      <= 1'b0;
                    gate_reg[gi + NB] <= 1'b0;
                end else begin
                    gate_reg[gi]      <= hs_next;
                    gate_reg[gi + NB] <= ls_next;
                    if ((hs_q && !hs_next) || (ls_q && !ls_next)) begin
                        dead_reg <= DW'(DEAD_CYCLES);
                    end else if (dead_reg != '0) begin
                        dead_reg <= dead_reg - DW'(1);
                    end
                end
            end

            sequence s_high_off;
                $fell(hs_q);
            endsequence
            a_dead_gap: assert property (@(posedge core_clk_in)
                disable iff (!rst_n_in)
                s_high_off |-> !ls_q [*8])
                else $error("low side on inside dead time");
            a_no_cross: assert property (@(posedge core_clk_in)
                disable iff (!rst_n_in) !(hs_q && ls_q))
                else $error("both switches of a bridge on");
        end
    endgenerate

    assign gate_drive_out = hbfp_pkg::hbfp_switch_t'(gate_reg);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_oc_gate_off: assert property (
        (|($past(oc_flag_reg) & gate_reg)) == 1'b0)
        else $error("switch on while its overcurrent flag set");
    a_oc_after_clamp: assert property (
        $rose(oc_flag_reg[0]) |-> $past(current_limit_out.high[0]))
        else $error("overcurrent latched without clamp phase");
    a_tsd_all_off: assert property (
        status_reg.thermal_shutdown_flag |=> gate_reg == '0)
        else $error("output on during thermal shutdown");
    a_supply_off: assert property (
        (uv_s || ov_s) |=> gate_reg == '0)
        else $error("output on during supply fault");
    a_set_wins: assert property (
        enable_s |=> (oc_flag_reg & $past(oc_done)) == $past(oc_done))
        else $error("overcurrent event lost");
    a_clear_needs_op: assert property (
        (enable_s && !clr_ok) |=>
        (ol_flag_reg & $past(ol_flag_reg)) == $past(ol_flag_reg))
        else $error("flag cleared without operation bit");
    a_enable_reset: assert property (
        !enable_s |=> (gate_reg == '0) && (oc_flag_reg == '0)
        && !status_reg.power_up_seen_flag)
        else $error("enable low did not reset");
    a_warn_keeps_on: assert property (
        ($rose(status_reg.thermal_warning_flag) && stage_ok
         && $stable(request) && $stable(stage_ok)) |-> gate_reg ==
        $past(gate_reg))
        else $error("thermal warning changed outputs");

endmodule : hbfp_top

`default_nettype wire

// ---- testbench/hbfp_host_model.sv ----
`default_nettype none

module hbfp_host_model (
    input  wire logic             core_clk_in,
    output hbfp_pkg::hbfp_clear_t clear_select_out,
    output logic                  clear_strobe_out,
    output logic                  access_operation_bit_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        clear_strobe_out         = 1'b0;
        access_operation_bit_out = 1'b0;
        clear_select_out         = '0;
    end

    // ------------------------------------------------------------------
    // One status access: op 1 reads and clears, op 0 only reads
    // ------------------------------------------------------------------
    task automatic access(input logic op, input hbfp_pkg::hbfp_clear_t sel);
        @(posedge core_clk_in);
        clear_strobe_out         <= 1'b1;
        access_operation_bit_out <= op;
        clear_select_out         <= sel;
        @(posedge core_clk_in);
        clear_strobe_out         <= 1'b0;
        // Released lines show the inverse, not the last value
        access_operation_bit_out <= ~op;
        clear_select_out         <= ~sel;
    endtask : access
endmodule : hbfp_host_model

`default_nettype wire

// ---- testbench/half_bridge_fault_protection_tb.sv ----
`default_nettype none

module half_bridge_fault_protection_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk, rst_n, enable, tw, ts, uv, ov, mask;
    logic                   strobe, op, gfi;
    hbfp_pkg::hbfp_switch_t ctrl, oc_raw, uc_raw, gate, limit, oc_st, ol_st;
    hbfp_pkg::hbfp_clear_t  sel;
    hbfp_pkg::hbfp_global_t gs;
    logic [32:0]            obs;
    int                     mismatches, n_checks;

    assign obs = {gate, oc_st, ol_st, gs, gfi};

    hbfp_top #(.OC_CYCLES(4), .OL_CYCLES(4), .DEAD_CYCLES(8)) i_dut (
        .core_clk_in                  (clk),
        .rst_n_in                     (rst_n),
        .enable_in                    (enable),
        .bridge_activation_control_in (ctrl),
        .overcurrent_raw_in           (oc_raw),
        .undercurrent_raw_in          (uc_raw),
        .thermal_warning_raw_in       (tw),
        .thermal_shutdown_raw_in      (ts),
        .supply_under_voltage_raw_in  (uv),
        .supply_over_voltage_raw_in   (ov),
        .open_load_mask_in            (mask),
        .clear_strobe_in              (strobe),
        .access_operation_bit_in      (op),
        .clear_select_in              (sel),
        .gate_drive_out               (gate),
        .current_limit_out            (limit),
        .overcurrent_status_out       (oc_st),
        .open_load_status_out         (ol_st),
        .global_status_one_out        (gs),
        .global_fault_indicator_out   (gfi)
    );

    hbfp_host_model i_host (
        .core_clk_in              (clk),
        .clear_select_out         (sel),
        .clear_strobe_out         (strobe),
        .access_operation_bit_out (op)
    );

    always #12.5 clk = ~clk;

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    task automatic chk1(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk1

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk8

    // Obs index: gfi 0, global 1+b, open-load 9+s, overcurrent 17+s, gate 25+s
    task automatic wait_obs(input int idx, input logic val, input int lim);
        int i;
        i = 0;
        @(negedge clk);
        while (obs[idx] !== val && i < lim) begin
            @(negedge clk);
            i++;
        end
        chk1(obs[idx], val, $sformatf("obs bit %0d", idx));
    endtask : wait_obs

    // Clear select bit for a flag at obs index idx
    task automatic clr(input logic o, input int idx);
        i_host.access(o, hbfp_pkg::hbfp_clear_t'(24'h00_0001 << (idx - 1)));
    endtask : clr

    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    always @(negedge clk) begin
        if (rst_n === 1'b1 && (gate.high & gate.low) !== 4'h0) begin
            mismatches++;
            $display("MISMATCH t=%0t both sides on", $time);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        clk = 0; rst_n = 0; enable = 1; tw = 0; ts = 0; uv = 0; ov = 0;
        mask = 1; ctrl = '0; oc_raw = '0; uc_raw = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk8(gs, 8'h00, "status after reset");
        chk1(gfi, 1'b1, "fault after reset");
        clr(1'b1, 4);
        wait_obs(4, 1'b1, 2);
        chk1(gfi, 1'b0, "fault clear");
        done("power_up");

        @(posedge clk) ctrl <= hbfp_pkg::hbfp_switch_t'(8'h01);
        wait_obs(25, 1'b1, 20);
        @(posedge clk) oc_raw <= hbfp_pkg::hbfp_switch_t'(8'h01);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk1(limit.high[0], 1'b1, "clamp");
        chk1(gate.high[0], 1'b1, "no early off");
        wait_obs(17, 1'b1, 20);
        wait_obs(25, 1'b0, 3);
        chk1(limit.high[0], 1'b0, "clamp ends");
        chk1(gs.load_fault_summary, 1'b1, "load fault oc");
        @(posedge clk) oc_raw <= '0;
        repeat (5) @(negedge clk);
        chk1(gate.high[0], 1'b0, "stays off");
        clr(1'b0, 17);
        wait_obs(17, 1'b1, 0);
        clr(1'b1, 17);
        wait_obs(17, 1'b0, 2);
        wait_obs(25, 1'b1, 20);
        chk1(gs.load_fault_summary, 1'b0, "load fault gone");
        done("overcurrent");

        @(posedge clk) uc_raw <= hbfp_pkg::hbfp_switch_t'(8'h01);
        wait_obs(9, 1'b1, 20);
        chk1(gate.high[0], 1'b1, "open load keeps on");
        chk1(gs.load_fault_summary, 1'b1, "load fault ol");
        chk1(gfi, 1'b0, "masked");
        @(posedge clk) mask <= 1'b0;
        @(negedge clk) chk1(gfi, 1'b1, "unmasked");
        clr(1'b1, 9);
        wait_obs(9, 1'b0, 0);
        wait_obs(9, 1'b1, 8);
        @(posedge clk) uc_raw <= '0;
        clr(1'b1, 9);
        wait_obs(9, 1'b0, 2);
        done("open_load");

        @(posedge clk) tw <= 1'b1;
        wait_obs(2, 1'b1, 8);
        chk1(gate.high[0], 1'b1, "warning keeps on");
        clr(1'b1, 2);
        wait_obs(2, 1'b1, 0);
        @(posedge clk) tw <= 1'b0;
        repeat (4) @(posedge clk);
        clr(1'b1, 2);
        wait_obs(2, 1'b0, 2);
        done("warning");

        @(posedge clk) ts <= 1'b1;
        wait_obs(3, 1'b1, 8);
        wait_obs(25, 1'b0, 3);
        @(posedge clk) ts <= 1'b0;
        repeat (10) @(negedge clk);
        chk1(gate.high[0], 1'b0, "shutdown latched");
        clr(1'b1, 3);
        wait_obs(25, 1'b1, 20);
        done("shutdown");

        for (int k = 0; k < 2; k++) begin
            @(posedge clk) {uv, ov} <= (k == 0) ? 2'b10 : 2'b01;
            wait_obs(6 - k, 1'b1, 8);
            wait_obs(25, 1'b0, 3);
            @(posedge clk) {uv, ov} <= 2'b00;
            wait_obs(25, 1'b1, 20);
            chk1(obs[6-k], 1'b1, "supply flag latched");
            clr(1'b1, 6 - k);
            wait_obs(6 - k, 1'b0, 2);
        end
        done("supply");

        @(posedge clk) ctrl <= hbfp_pkg::hbfp_switch_t'(8'h10);
        wait_obs(25, 1'b0, 4);
        repeat (8) begin
            @(negedge clk) chk1(gate.low[0], 1'b0, "dead time");
        end
        wait_obs(29, 1'b1, 1);
        done("dead_time");

        @(posedge clk) tw <= 1'b1;
        wait_obs(2, 1'b1, 8);
        @(posedge clk) begin
            tw     <= 1'b0;
            enable <= 1'b0;
        end
        repeat (5) @(negedge clk);
        chk8(gate, 8'h00, "enable low gates");
        chk8(gs, 8'h00, "enable low status");
        @(posedge clk) enable <= 1'b1;
        wait_obs(29, 1'b1, 20);
        chk1(gfi, 1'b1, "power up shown");
        done("enable");

        @(posedge clk) rst_n <= 1'b0;
        @(negedge clk);
        chk8(gate, 8'h00, "reset gates");
        chk8(gs, 8'h00, "reset status");
        done("reset");
        close_out();
    end
endmodule : half_bridge_fault_protection_tb

`default_nettype wire
